/* core/sblb_pkg.sv */
// Package: register map, field layout and constants of the baud and LIN break block
package sblb_pkg;

  // ****************************************
  // Register map (byte addresses, one 32-bit word apart)
  // ****************************************
  localparam logic [3:0] ADDR_BAUD_RATE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PRESCALER_CTRL = 4'h4;
  localparam logic [3:0] ADDR_SYSTEM_OPTION  = 4'h8;
  localparam logic [3:0] ADDR_STATUS         = 4'hC;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BRC_TXBRK_BIT = 7;
  localparam int BRC_RXFLT_BIT = 6;
  localparam int BRC_CPS_LSB   = 4;
  localparam int BRC_RDS_LSB   = 0;
  localparam int PSC_FPS_LSB   = 5;
  localparam int PSC_CIS_LSB   = 0;
  localparam int SYS_SRC_BIT   = 0;
  localparam int SYS_ENA_BIT   = 1;
  localparam int STS_BRK_BIT   = 0;
  localparam int STS_FRAME_BIT = 1;
  localparam int STS_RF_BIT    = 2;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] BRC_RESET      = 8'h00;
  localparam logic [7:0] PSC_RESET      = 8'h00;
  localparam logic [1:0] SYS_RESET      = 2'h0;
  localparam logic [5:0] OVERSAMPLE     = 6'h3F;  // Divide by 64, minus one
  localparam logic [4:0] INSERT_FRAME   = 5'h1F;  // 32 output cycles per frame, minus one
  localparam logic [3:0] RX_BREAK_STD   = 4'hA;   // Ten low bits: ordinary break
  localparam logic [3:0] RX_BREAK_LIN8  = 4'hB;
  localparam logic [3:0] RX_BREAK_LIN9  = 4'hC;
  localparam logic [3:0] TX_BREAK_STD   = 4'hA;
  localparam logic [3:0] TX_BREAK_LIN8  = 4'hD;
  localparam logic [3:0] TX_BREAK_LIN9  = 4'hE;
  localparam logic [3:0] SAMPLE_MID     = 4'h8;   // Sixteenth ticks to mid-bit
  localparam logic [3:0] SUB_LAST       = 4'hF;

  // Coarse divisor decode, minus one
  function automatic logic [3:0] sblb_coarse_div_m1(input logic [1:0] sel);
    case (sel)
      2'h0:    sblb_coarse_div_m1 = 4'h0;
      2'h1:    sblb_coarse_div_m1 = 4'h2;
      2'h2:    sblb_coarse_div_m1 = 4'h3;
      default: sblb_coarse_div_m1 = 4'hC;
    endcase
  endfunction

endpackage

/* core/sblb_div_stage.sv */
// Programmable modulo counter that emits a one-cycle tick per period
`timescale 1ns/100ps
module sblb_div_stage #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Count control
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  // Period tick
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } sblb_div_state_t;

  sblb_div_state_t st_reg;
  sblb_div_state_t st_next;

  // Wrap at limit; a lowered limit still wraps cleanly
  always_comb begin
    st_next = st_reg;
    if (en) begin
      if (st_reg.cnt >= limit) begin
        st_next.cnt = '0;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  assign tick = en && (st_reg.cnt >= limit);

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

/* core/sblb_top.sv */
// Baud rate generator, LIN break detection and generation, Avalon-MM registers
`timescale 1ns/100ps

module sblb_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Oscillator clock, sampled as a synchronous input
  input  wire logic        oscillator_clock,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Character length select from the data path
  input  wire logic        char_nine_bit,
  // Serial line
  input  wire logic        rxd,
  output logic             txd,
  // Transmit break request and status
  input  wire logic        tx_break_req,
  output logic             tx_break_busy,
  // Bit clocks to receiver and transmitter
  output logic             rx_sample_tick,
  output logic             tx_bit_tick,
  // Receive flags toward the data path
  output logic             break_flag,
  output logic             framing_error_flag,
  output logic             receive_full_flag
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]  baud_rate_ctrl;
    logic [7:0]  prescaler_ctrl;
    logic [1:0]  system_option_reg_two;
    logic        osc_q;
    logic        ack;
    logic [31:0] rdata;
    logic [4:0]  frame_cnt;
    logic        insert_hold;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_low_bits;
    logic        rx_armed;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bits;
    logic        tx_active;
    logic        brk;
    logic        ferr;
    logic        rf;
  } sblb_state_t;

  sblb_state_t st_reg;
  sblb_state_t st_next;

  // ****************************************
  // Field views
  // ****************************************
  logic       lin_tx_break_enable;
  logic       lin_rx_break_filter;
  logic [1:0] coarse_prescale_select;
  logic [2:0] rate_divider_select;
  logic [2:0] fine_prescale_select;
  logic [4:0] clock_insert_select;
  logic       baud_clock_source_select;
  logic       serial_unit_enable;

  assign lin_tx_break_enable      = st_reg.baud_rate_ctrl[sblb_pkg::BRC_TXBRK_BIT];
  assign lin_rx_break_filter      = st_reg.baud_rate_ctrl[sblb_pkg::BRC_RXFLT_BIT];
  assign coarse_prescale_select   = st_reg.baud_rate_ctrl[sblb_pkg::BRC_CPS_LSB +: 2];
  assign rate_divider_select      = st_reg.baud_rate_ctrl[sblb_pkg::BRC_RDS_LSB +: 3];
  assign fine_prescale_select     = st_reg.prescaler_ctrl[sblb_pkg::PSC_FPS_LSB +: 3];
  assign clock_insert_select      = st_reg.prescaler_ctrl[sblb_pkg::PSC_CIS_LSB +: 5];
  assign baud_clock_source_select = st_reg.system_option_reg_two[sblb_pkg::SYS_SRC_BIT];
  assign serial_unit_enable       = st_reg.system_option_reg_two[sblb_pkg::SYS_ENA_BIT];

  // ****************************************
  // Rate generator chain
  // ****************************************
  logic       src_tick;
  logic       fine_en;
  logic       fine_tick;
  logic       fine_out;
  logic       coarse_tick;
  logic [6:0] pow2_limit;
  logic       pow2_tick;
  logic       over_tick;

  // Source select: oscillator edge or every bus clock
  always_comb begin
    src_tick = baud_clock_source_select ? (oscillator_clock && !st_reg.osc_q) : 1'b1;
  end

  // Inserted clocks stall the fine stage for one source tick
  assign fine_en  = src_tick && serial_unit_enable && !st_reg.insert_hold;
  // bypass passes source ticks straight through
  assign fine_out = (fine_prescale_select == 3'h0) ? (src_tick && serial_unit_enable)
                                                    : fine_tick;

  // fine divisor is select plus one
  sblb_div_stage #(.W(3)) u_fine (
    .clk   (clk),
    .srst  (srst),
    .en    (fine_en),
    .limit (fine_prescale_select),
    .tick  (fine_tick)
  );

  // coarse divisor 1, 3, 4 or 13
  sblb_div_stage #(.W(4)) u_coarse (
    .clk   (clk),
    .srst  (srst),
    .en    (fine_out),
    .limit (sblb_pkg::sblb_coarse_div_m1(coarse_prescale_select)),
    .tick  (coarse_tick)
  );

  assign pow2_limit = 7'((8'h01 << rate_divider_select) - 8'h01);

  sblb_div_stage #(.W(7)) u_pow2 (
    .clk   (clk),
    .srst  (srst),
    .en    (coarse_tick),
    .limit (pow2_limit),
    .tick  (pow2_tick)
  );

  // fixed divide by 4, four ticks per sixteenth
  sblb_div_stage #(.W(2)) u_over (
    .clk   (clk),
    .srst  (srst),
    .en    (pow2_tick),
    .limit (2'h3),
    .tick  (over_tick)
  );

  // one tick stream shared by receiver and transmitter
  assign rx_sample_tick = over_tick;
  assign tx_bit_tick    = over_tick && (st_reg.tx_sub == sblb_pkg::SUB_LAST);
  assign tx_break_busy  = st_reg.tx_active;
  assign txd            = !st_reg.tx_active;
  assign break_flag         = st_reg.brk;
  assign framing_error_flag = st_reg.ferr;
  assign receive_full_flag  = st_reg.rf;
  assign avs_readdata       = st_reg.rdata;
  // One wait cycle, then acknowledge
  // Read data are captured while waiting, so no path runs from address to data
  assign avs_waitrequest    = (avs_read || avs_write) && !st_reg.ack;

  // ****************************************
  // Next-state logic
  // ****************************************
  logic [3:0] rx_need;
  logic [3:0] tx_need;
  logic       bus_take;
  logic       sts_read;

  // length select moves both LIN thresholds up by one bit
  always_comb begin
    rx_need = !lin_rx_break_filter ? sblb_pkg::RX_BREAK_STD :
              (char_nine_bit ? sblb_pkg::RX_BREAK_LIN9 : sblb_pkg::RX_BREAK_LIN8);
    tx_need = !lin_tx_break_enable ? sblb_pkg::TX_BREAK_STD :
              (char_nine_bit ? sblb_pkg::TX_BREAK_LIN9 : sblb_pkg::TX_BREAK_LIN8);
  end

  assign bus_take = (avs_read || avs_write) && st_reg.ack;
  assign sts_read = bus_take && avs_read && (avs_address == sblb_pkg::ADDR_STATUS);

  always_comb begin
    st_next       = st_reg;
    st_next.osc_q = oscillator_clock;
    st_next.ack   = (avs_read || avs_write) && !st_reg.ack;

    // one held source tick per inserted clock, in the frame's first slots
    // Holding rather than skipping keeps each stretch exactly one source tick
    st_next.insert_hold = 1'b0;
    if (fine_tick) begin
      st_next.frame_cnt = st_reg.frame_cnt + 5'h01;
      if (st_reg.frame_cnt < clock_insert_select) begin
        st_next.insert_hold = 1'b1;
      end
    end
    if (st_reg.insert_hold && !src_tick) begin
      st_next.insert_hold = 1'b1;  // Wait for the source tick that is swallowed
    end

    // Register writes, low byte lane only
    if (bus_take && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        sblb_pkg::ADDR_BAUD_RATE_CTRL: st_next.baud_rate_ctrl = avs_writedata[7:0];
        sblb_pkg::ADDR_PRESCALER_CTRL: st_next.prescaler_ctrl = avs_writedata[7:0];
        sblb_pkg::ADDR_SYSTEM_OPTION:  st_next.system_option_reg_two = avs_writedata[1:0];
        default: ;
      endcase
    end

    // Read data captured in the waiting cycle, shown at the acknowledge edge
    st_next.rdata = 32'h0000_0000;
    if (avs_read && !st_reg.ack) begin
      case (avs_address)
        sblb_pkg::ADDR_BAUD_RATE_CTRL: st_next.rdata = {24'h000000, st_reg.baud_rate_ctrl};
        sblb_pkg::ADDR_PRESCALER_CTRL: st_next.rdata = {24'h000000, st_reg.prescaler_ctrl};
        sblb_pkg::ADDR_SYSTEM_OPTION:
          st_next.rdata = {30'h0000_0000, st_reg.system_option_reg_two};
        sblb_pkg::ADDR_STATUS:
          st_next.rdata = {28'h0000000, st_reg.tx_active, st_reg.rf, st_reg.ferr, st_reg.brk};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end else if (avs_read) begin
      st_next.rdata = st_reg.rdata;
    end

    // Reading status clears only the flags it reported; a flag set after the
    // capture survives, and a new break in this cycle wins below
    if (sts_read) begin
      st_next.brk  = st_reg.brk  & ~st_reg.rdata[sblb_pkg::STS_BRK_BIT];
      st_next.ferr = st_reg.ferr & ~st_reg.rdata[sblb_pkg::STS_FRAME_BIT];
      st_next.rf   = st_reg.rf   & ~st_reg.rdata[sblb_pkg::STS_RF_BIT];
    end

    // Receive low-time measurement at mid-bit samples
    // Counting at mid-bit lets detection land half a bit before the count
    if (rx_sample_tick) begin
      st_next.rx_sub = st_reg.rx_sub + 4'h1;
      if (rxd) begin
        st_next.rx_sub      = 4'h0;
        st_next.rx_low_bits = 4'h0;
        st_next.rx_armed    = 1'b1;  // Line must go high before the next break
      end else if (st_reg.rx_sub == sblb_pkg::SAMPLE_MID && st_reg.rx_armed) begin
        st_next.rx_low_bits = st_reg.rx_low_bits + 4'h1;
        // whole-bit count at the 11-bit threshold rejects 10.35, accepts 11.05 and up
        if (st_reg.rx_low_bits + 4'h1 == rx_need) begin
          st_next.rx_armed = 1'b0;
          st_next.brk  = 1'b1;
          st_next.ferr = 1'b1;
          st_next.rf   = 1'b1;
        end
      end
    end
    if (!serial_unit_enable) begin
      st_next.rx_sub      = 4'h0;
      st_next.rx_low_bits = 4'h0;
    end

    // Disabling the unit mid-break freezes the count with the line held low
    // transmit break counted in bit ticks, independent of the receive side
    if (!st_reg.tx_active && tx_break_req && serial_unit_enable) begin
      st_next.tx_active = 1'b1;
      st_next.tx_bits   = 4'h0;
      st_next.tx_sub    = 4'h0;
    end else if (st_reg.tx_active && over_tick) begin
      st_next.tx_sub = st_reg.tx_sub + 4'h1;
      if (tx_bit_tick) begin
        st_next.tx_bits = st_reg.tx_bits + 4'h1;
        if (st_reg.tx_bits + 4'h1 == tx_need) begin
          st_next.tx_active = 1'b0;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // all fields clear at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg                       <= '0;
      st_reg.baud_rate_ctrl        <= sblb_pkg::BRC_RESET;
      st_reg.prescaler_ctrl        <= sblb_pkg::PSC_RESET;
      st_reg.system_option_reg_two <= sblb_pkg::SYS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

/* tb/sblb_lin_node.sv */
// Far-side serial node: drives low stretches onto rxd, times low stretches on txd
`timescale 1ns/100ps
module sblb_lin_node (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic txd,
  output logic     rxd,
  // Last low stretch seen on txd, in clocks
  output int       low_len
);
  int run = 0;
  // Line is pulled up, so it idles high between frames
  initial rxd = 1'b1;
  initial low_len = 0;
  // dominant stretch, then recessive so the receiver can rearm
  task automatic send_low(input int cyc);
    rxd <= 1'b0;
    repeat (cyc) @(posedge clk);
    rxd <= 1'b1;
    repeat (192) @(posedge clk);
  endtask
  // break length measured here, never trusted to the sender
  always @(posedge clk) begin
    if (!txd) run <= run + 1;
    else begin
      if (run > 0) low_len <= run;
      run <= 0;
    end
  end
endmodule

/* tb/sblb_monitor.sv */
// Assertion checker on the ports of the baud and LIN break block
`timescale 1ns/100ps
module sblb_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Line, ticks and flags
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        tx_break_busy,
  input wire logic        rx_sample_tick,
  input wire logic        tx_bit_tick,
  input wire logic        break_flag,
  input wire logic        framing_error_flag,
  input wire logic        receive_full_flag
);
  // ****
  // Properties
  // ****
  logic req;
  logic rd_ok;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Taken read cycle, the only one where readdata counts
  assign req   = avs_read | avs_write;
  assign rd_ok = avs_read & ~avs_waitrequest;
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("first request cycle not stalled");
  chk_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request stalled more than one cycle");
  chk_unmapped_zero: assert property (
    rd_ok && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_tick_gap: assert property (rx_sample_tick |=> !rx_sample_tick [*3])
    else $error("sample ticks closer than four clocks");
  logic [3:0] tx_bits_seen;
  // Bit ticks within the current break, cleared while idle
  always_ff @(posedge clk) begin
    if (srst || !tx_break_busy) begin
      tx_bits_seen <= 4'h0;
    end else if (tx_bit_tick) begin
      tx_bits_seen <= tx_bits_seen + 4'h1;
    end
  end
  chk_bit_on_sample: assert property (
    tx_bit_tick |-> rx_sample_tick && tx_break_busy)
    else $error("bit tick outside the shared sample stream");
  chk_break_bits: assert property ($fell(tx_break_busy) |->
    tx_bits_seen == 4'hA || tx_bits_seen == 4'hD || tx_bits_seen == 4'hE)
    else $error("break ended after an illegal bit count");
  chk_flags_set: assert property (
    $rose(break_flag) |-> framing_error_flag && receive_full_flag)
    else $error("break without framing and full flags");
  chk_break_low: assert property ($rose(break_flag) |-> $past(rxd, 4) == 1'b0)
    else $error("break flagged while line high");
  chk_flag_hold: assert property (
    break_flag && !(rd_ok && avs_address == 4'hC) |=> break_flag)
    else $error("break flag lost without status read");
  // Main scenarios reached
  cover property ($rose(break_flag));
  cover property ($fell(tx_break_busy));
  cover property (rd_ok && avs_address == 4'hC);
endmodule

bind sblb_top sblb_monitor u_mon (
  .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rxd(rxd), .txd(txd), .tx_break_busy(tx_break_busy), .rx_sample_tick(rx_sample_tick),
  .tx_bit_tick(tx_bit_tick),
  .break_flag(break_flag), .framing_error_flag(framing_error_flag),
  .receive_full_flag(receive_full_flag));

/* tb/tb.sv */
// Self-checking bench of the baud and LIN break block
`timescale 1ns/100ps
module tb;
  // ****
  // Signals
  // ****
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        osc = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hF;
  logic        nine = 1'b0;
  logic        brk = 1'b0;
  logic [31:0] rdat, q;
  logic        wrq, rxd, txd, busy, stick, btick, bf, ferr, rf;
  int          n_errors = 0;
  int          compares = 0;
  int          seed = 32'hCF0F;
  int          oc = 0;
  int          low_len;
  // 50 MHz clock; oscillator input runs at a sixth of it
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    oc <= (oc + 1) % 6;
    osc <= (oc < 3);
  end
  sblb_top u_dut (
    .clk(clk), .srst(srst), .oscillator_clock(osc),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wrq),
    .char_nine_bit(nine), .rxd(rxd), .txd(txd), .tx_break_req(brk),
    .tx_break_busy(busy), .rx_sample_tick(stick), .tx_bit_tick(btick),
    .break_flag(bf), .framing_error_flag(ferr), .receive_full_flag(rf));
  sblb_lin_node u_node (.clk(clk), .txd(txd), .rxd(rxd), .low_len(low_len));
  // ****
  // Tasks
  // ****
  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fail();
    n_errors++;
    conclude();
  endtask
  task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // Break lengths are judged to within half a bit
  task automatic cmp_len(input string nm, input int e, input int g);
    compares++;
    if (g < e - 32 || g > e + 31) begin
      n_errors++;
      $display("mismatch %s exp %0d got %0d", nm, e, g);
    end
  endtask
  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h000000, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wrq !== 1'b0 && i < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (i >= 20) fail();
  endtask
  // unit is disabled while the prescalers change
  task automatic cfg(input logic [7:0] b, input logic [7:0] p, input logic s);
    bus(1'b1, 4'h8, 8'h00);
    bus(1'b1, 4'h0, b);
    bus(1'b1, 4'h4, p);
    bus(1'b1, 4'h8, {6'h00, 1'b1, s});
  endtask
  // Clocks across n sample-tick periods, skipping the first one after enable
  task automatic meas(input int n, output int c);
    int k;
    k = 0;
    c = 0;
    for (int g = 0; g < 30000 && k <= n + 1; g++) begin
      @(posedge clk);
      if (k > 1) c++;
      if (stick === 1'b1) k++;
    end
    if (k <= n + 1) fail();
  endtask
  function automatic int bit_clk(input logic [7:0] b, input logic [7:0] p);
    int cd;
    cd = (b[5:4] == 2'h0) ? 1 : (b[5:4] == 2'h1) ? 3 : (b[5:4] == 2'h2) ? 4 : 13;
    return 64 * cd * (1 << b[2:0]) * ((p[7:5] == 3'h0) ? 1 : int'(p[7:5]) + 1);
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    int c, thr, len;
    logic [7:0] b, p, d;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, a[3:0], 8'h00);
      cmp_val("reset value", 32'h0, q);
    end
    // Random read back; option register keeps two bits only
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      for (int a = 0; a < 12; a += 4) begin
        bus(1'b1, a[3:0], d);
        bus(1'b0, a[3:0], 8'h00);
        cmp_val("readback", {24'h0, d & ((a == 8) ? 8'h03 : 8'hFF)}, q);
      end
    end
    // Dead byte lane and unmapped place leave nothing behind
    be <= 4'hE;
    bus(1'b1, 4'h0, ~d);
    be <= 4'hF;
    bus(1'b1, 4'h2, d);
    bus(1'b0, 4'h0, 8'h00);
    cmp_val("lane off", {24'h0, d}, q);
    bus(1'b0, 4'h2, 8'h00);
    cmp_val("unmapped", 32'h0, q);
    // Every coarse, rate and fine code, bus clock source
    for (int i = 0; i < 20; i++) begin
      b = (i < 4) ? 8'(i << 4) : (i < 12) ? 8'(i - 4) : 8'h00;
      p = (i >= 12) ? 8'((i - 12) << 5) : 8'h00;
      cfg(b, p, 1'b0);
      meas(16, c);
      cmp_val("bit time", bit_clk(b, p), c);
    end
    // Insertion over 32 bits gives whole frames of the fine stage
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      p = {1'b0, d[7:6] | 2'b01, d[4:0]};
      cfg(8'h00, p, 1'b0);
      meas(512, c);
      cmp_val("frame time", 32 * bit_clk(8'h00, p) + 64 * d[4:0], c);
    end
    cfg(8'h00, 8'h00, 1'b1);
    meas(16, c);
    cmp_val("osc bit time", 32'd384, c);
    // All LIN option and length combinations
    for (int m = 0; m < 8; m++) begin
      nine <= m[0];
      cfg({m[2:1], 6'h00}, 8'h00, 1'b0);
      thr = m[1] ? 11 + m[0] : 10;
      len = m[2] ? 13 + m[0] : 10;
      u_node.send_low((thr - 1) * 64);
      cmp_val("short low", 32'h0, bf);
      bus(1'b0, 4'hC, 8'h00);
      u_node.send_low((thr + 1) * 64);
      cmp_val("break flags", 32'h7, {rf, ferr, bf});
      bus(1'b0, 4'hC, 8'h00);
      cmp_val("status", 32'h7, q);
      cmp_val("flag cleared", 32'h0, bf);
      brk <= 1'b1;
      @(posedge clk);
      brk <= 1'b0;
      for (int g = 0; g < 3000; g++) begin
        @(posedge clk);
        if (g > 100 && busy === 1'b0 && txd === 1'b1) break;
      end
      if (busy !== 1'b0) fail();
      @(posedge clk);
      cmp_len("break length", len * 64, low_len);
    end
    conclude();
  end
endmodule
